// ### design/pair_monitor.sv
`timescale 1ns/1ps
// Watches one two-channel safety input: synchronises both channels,
// checks that they agree in time and latches a fault until released.
module pair_monitor
    import safety_start_pkg::*;
(
    input  wire logic core_clk,     // System clock.
    input  wire logic reset_n,      // Asynchronous reset, active low.
    input  wire logic ms_tick,      // One-cycle pulse every millisecond.
    input  wire logic chan_one_pin, // First channel from the pin.
    input  wire logic chan_two_pin, // Second channel from the pin.
    output logic      pair_ok,      // Both channels active, no fault.
    output logic      pair_off,     // Both channels inactive.
    output logic      pair_fault    // Latched interlock or skew fault.
);
    logic [1:0]          meta_r;    // First synchroniser stage.
    logic [1:0]          chan_r;    // Second synchroniser stage.
    logic [1:0]          prev_r;    // Channels one cycle earlier.
    logic [MS_CNT_W-1:0] skew_r;    // Milliseconds spent disagreeing.
    logic                fault_r;   // Latched fault.
    logic                both_on;   // Both channels active.
    logic                both_off;  // Both channels inactive.
    logic                split;     // Channels disagree.
    logic                lone_drop; // One channel fell while other held.

    assign both_on   = &chan_r;
    assign both_off  = ~|chan_r;
    assign split     = chan_r[0] ^ chan_r[1];
    assign lone_drop = (&prev_r) && split;

    // Two flip-flops per channel before any logic looks at the pins.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 2'h0;
            chan_r <= 2'h0;
            prev_r <= 2'h0;
        end else begin
            meta_r <= {chan_two_pin, chan_one_pin};
            chan_r <= meta_r;
            prev_r <= chan_r;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            skew_r <= '0;
        end else if (!split) begin
            skew_r <= '0;
        end else if (ms_tick && skew_r < MS_CNT_W'(SYNC_MS)) begin
            skew_r <= skew_r + MS_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_r <= 1'b0;
        end else if (lone_drop || skew_r >= MS_CNT_W'(SYNC_MS)) begin
            // A channel dropping alone, or a skew past the window, is a fault.
            fault_r <= 1'b1;
        end else if (both_off) begin
            fault_r <= 1'b0;
        end
    end

    assign pair_ok    = both_on && !fault_r;
    assign pair_off   = both_off;
    assign pair_fault = fault_r;

endmodule : pair_monitor

// ### design/safety_start_control.sv
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
// Start and output-enable control for six two-channel safety inputs,
// with an APB slave for control and status.
module safety_start_control
    import safety_start_pkg::*;
#(
    // Clock cycles per millisecond tick; shorten for simulation.
    parameter int unsigned TICK_CYCLES = MS_CYCLES
)
(
    input  wire logic        core_clk,            // System clock, 10 MHz.
    input  wire logic        reset_n,             // Power-on reset, active low.
    input  wire logic        input_a_channel_one, // Input A, first channel.
    input  wire logic        input_a_channel_two, // Input A, second channel.
    input  wire logic        input_b_channel_one, // Input B, first channel.
    input  wire logic        input_b_channel_two, // Input B, second channel.
    input  wire logic        input_c_channel_one, // Input C, first channel.
    input  wire logic        input_c_channel_two, // Input C, second channel.
    input  wire logic        input_d_channel_one, // Input D, first channel.
    input  wire logic        input_d_channel_two, // Input D, second channel.
    input  wire logic        input_e_channel_one, // Input E, first channel.
    input  wire logic        input_e_channel_two, // Input E, second channel.
    input  wire logic        input_f_channel_one, // Input F, first channel.
    input  wire logic        input_f_channel_two, // Input F, second channel.
    input  wire logic        start_in,            // Start input pin, active high.
    input  wire logic [2:0]  start_selector,      // Selector position minus one.
    input  wire logic        psel,                // APB select.
    input  wire logic        penable,             // APB enable.
    input  wire logic        pwrite,              // APB direction.
    input  wire logic [7:0]  paddr,               // APB byte address.
    input  wire logic [31:0] pwdata,              // APB write data.
    output logic             pready,              // APB ready.
    output logic [31:0]      prdata,              // APB read data.
    output logic             pslverr,             // APB error.
    output logic             safety_out_one,      // First safety output.
    output logic             safety_out_two       // Second safety output.
);
    // Tick divider state.
    logic [$clog2(TICK_CYCLES)-1:0] div_r;      // Cycle count within a tick.
    logic                           ms_tick_r;  // Millisecond tick pulse.

    // Pair monitor inputs and results.
    logic [PAIR_COUNT-1:0] ch_one;     // First channels gathered.
    logic [PAIR_COUNT-1:0] ch_two;     // Second channels gathered.
    logic [PAIR_COUNT-1:0] pair_ok;    // Pair active and healthy.
    logic [PAIR_COUNT-1:0] pair_off;   // Pair fully inactive.
    logic [PAIR_COUNT-1:0] pair_fault; // Pair faulted.

    // Start input and selector synchronisers.
    logic       start_meta_r;  // First stage of start input.
    logic       start_r;       // Synchronised start input.
    logic       start_prev_r;  // Start input one cycle earlier.
    logic [2:0] sel_meta_r;    // First stage of selector.
    logic [2:0] sel_sync_r;    // Synchronised selector.
    logic [2:0] sel_r;         // Selector caught after power-up.
    logic [1:0] sel_cnt_r;     // Cycles since reset release.
    logic       sel_taken_r;   // Selector has been caught.

    // Start control state.
    start_state_e        state_r;     // Current start state.
    start_state_e        state_nxt;   // Next start state.
    logic [MS_CNT_W-1:0] wait_r;      // Milliseconds since power-on.
    logic [MS_CNT_W-1:0] pulse_r;     // Milliseconds start held.
    logic                became_r;    // Inputs went active while held.
    logic [PAIR_COUNT-1:0] seen_off_r; // Pair seen inactive since power-up.
    logic                out_r;       // Safety output enable.
    logic                allow_r;     // Software output permission.

    // Derived conditions.
    logic all_ok;       // Every pair active and healthy, output allowed, selector caught.
    logic tested;       // Startup test satisfied or not selected.
    logic monitored;    // Monitored start selected.
    logic start_fall;   // Falling edge of the start input.
    logic pulse_long;   // Start pulse was long enough.
    logic wait_done;    // Power-on wait elapsed.

    assign ch_one = {input_f_channel_one, input_e_channel_one, input_d_channel_one,
                     input_c_channel_one, input_b_channel_one, input_a_channel_one};
    assign ch_two = {input_f_channel_two, input_e_channel_two, input_d_channel_two,
                     input_c_channel_two, input_b_channel_two, input_a_channel_two};

    genvar gi;
    generate
        for (gi = 0; gi < PAIR_COUNT; gi++) begin : g_pair
            pair_monitor u_pair (
                .core_clk     (core_clk),
                .reset_n      (reset_n),
                .ms_tick      (ms_tick_r),
                .chan_one_pin (ch_one[gi]),
                .chan_two_pin (ch_two[gi]),
                .pair_ok      (pair_ok[gi]),
                .pair_off     (pair_off[gi]),
                .pair_fault   (pair_fault[gi])
            );
        end
    endgenerate

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r     <= '0;
            ms_tick_r <= 1'b0;
        end else if (div_r == $bits(div_r)'(TICK_CYCLES - 1)) begin
            div_r     <= '0;
            ms_tick_r <= 1'b1;
        end else begin
            div_r     <= div_r + $bits(div_r)'(1);
            ms_tick_r <= 1'b0;
        end
    end

    // Start input and selector pass two flip-flops from the pins.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_meta_r <= 1'b0;
            start_r      <= 1'b0;
            start_prev_r <= 1'b0;
            sel_meta_r   <= 3'h0;
            sel_sync_r   <= 3'h0;
        end else begin
            start_meta_r <= start_in;
            start_r      <= start_meta_r;
            start_prev_r <= start_r;
            sel_meta_r   <= start_selector;
            sel_sync_r   <= sel_meta_r;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_cnt_r   <= 2'h0;
            sel_taken_r <= 1'b0;
            sel_r       <= 3'h0;
        end else if (!sel_taken_r) begin
            // Wait until the synchroniser holds the pin level, then freeze it.
            if (sel_cnt_r == 2'(SEL_LATCH_CYC)) begin
                sel_taken_r <= 1'b1;
                sel_r       <= sel_sync_r;
            end else begin
                sel_cnt_r <= sel_cnt_r + 2'h1;
            end
        end
    end

    assign monitored = sel_r[SEL_MONITOR_BIT];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            seen_off_r <= '0;
        end else if (sel_taken_r) begin
            seen_off_r <= seen_off_r | pair_off;
        end
    end

    assign tested = !sel_r[SEL_TEST_BIT] || (&seen_off_r);

    assign all_ok = (&pair_ok) && !(|pair_fault) && allow_r && sel_taken_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_r <= '0;
        end else if (ms_tick_r && !wait_done) begin
            wait_r <= wait_r + MS_CNT_W'(1);
        end
    end

    assign wait_done = wait_r >= MS_CNT_W'(POWER_WAIT_MS);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_r <= '0;
        end else if (state_r != ST_HELD) begin
            pulse_r <= '0;
        end else if (ms_tick_r && !pulse_long) begin
            pulse_r <= pulse_r + MS_CNT_W'(1);
        end
    end

    assign pulse_long = pulse_r >= MS_CNT_W'(START_PULSE_MS);
    assign start_fall = start_prev_r && !start_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            became_r <= 1'b0;
        end else if (state_r != ST_HELD) begin
            became_r <= 1'b0;
        end else if (all_ok) begin
            became_r <= 1'b1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (!monitored) begin
                    if (all_ok && start_r && tested) begin
                        state_nxt = ST_ON;
                    end
                end else if (start_r && wait_done && sel_taken_r) begin
                    state_nxt = ST_HELD;
                end
            end
            ST_HELD: begin
                if (start_fall) begin
                    if (pulse_long && became_r && all_ok && tested) begin
                        state_nxt = ST_ON;
                    end else begin
                        state_nxt = ST_OFF;
                    end
                end
            end
            ST_ON: begin
                if (!all_ok) begin
                    state_nxt = ST_OFF;
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_r <= 1'b0;
        end else begin
            out_r <= (state_nxt == ST_ON);
        end
    end

    assign safety_out_one = out_r;
    assign safety_out_two = out_r;

    // APB: one wait state, then ready with data or error.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= (paddr != CTRL_ADDR) && (paddr != STATUS_ADDR);
            prdata  <= 32'h0;
            if (!pwrite && paddr == CTRL_ADDR) begin
                prdata[CTRL_ALLOW_BIT] <= allow_r;
            end else if (!pwrite && paddr == STATUS_ADDR) begin
                prdata[ST_OUT_BIT]                     <= out_r;
                prdata[ST_OK_LSB +: PAIR_COUNT]        <= pair_ok;
                prdata[ST_FAULT_LSB +: PAIR_COUNT]     <= pair_fault;
                prdata[ST_SEL_LSB +: 3]                <= sel_r;
                prdata[ST_TESTED_BIT]                  <= tested;
                prdata[ST_STATE_LSB +: 2]              <= state_r;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control register write at the completing edge of the access.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            allow_r <= CTRL_RESET[0];
        end else if (psel && penable && pready && pwrite && paddr == CTRL_ADDR) begin
            allow_r <= pwdata[CTRL_ALLOW_BIT];
        end
    end

endmodule : safety_start_control

// ### design/safety_start_pkg.sv
// Contract
// - Watch six two-channel inputs for interlock.
// - Channels must agree within half a second.
// - Start function governs every output enabling.
// - Start type, startup test, dynamization chosen; the dynamization bit is stored but drives no logic.
// - Automatic start energizes within 100 ms; the code has no automatic start, start_in is always needed.
// - Any input inactive drops outputs within 20 ms.
// - Manual start needs start and inputs.
// - Manual start energizes within 100 ms.
// - Monitored start energizes on falling edge.
// - Monitored start energizes within 100 ms.
// - All inputs needed, all outputs together.
// - Startup test needs inactive-then-active inputs.
// - Selector sampled only at power-up.
package safety_start_pkg;

    // Number of two-channel safety inputs.
    localparam int unsigned PAIR_COUNT = 6;

    // Clock period and the millisecond time base.
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    // Times in milliseconds, counted in millisecond ticks.
    localparam int unsigned SYNC_MS        = 500;
    localparam int unsigned START_PULSE_MS = 80;
    localparam int unsigned POWER_WAIT_MS  = 3000;
    localparam int unsigned MS_CNT_W       = 12;

    // Selector fields: position minus one in three bits.
    localparam int unsigned SEL_TEST_BIT    = 0;
    localparam int unsigned SEL_MONITOR_BIT = 1;
    localparam int unsigned SEL_NODYN_BIT   = 2;
    localparam int unsigned SEL_LATCH_CYC   = 3;

    // Register byte addresses.
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;

    // Control register layout and reset value.
    localparam int unsigned CTRL_ALLOW_BIT = 0;
    localparam logic [0:0]  CTRL_RESET     = 1'h1;

    // Status register field positions.
    localparam int unsigned ST_OUT_BIT    = 0;
    localparam int unsigned ST_OK_LSB     = 1;
    localparam int unsigned ST_FAULT_LSB  = 7;
    localparam int unsigned ST_SEL_LSB    = 13;
    localparam int unsigned ST_TESTED_BIT = 16;
    localparam int unsigned ST_STATE_LSB  = 17;

    // Start control states.
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_HELD = 2'b01,
        ST_ON   = 2'b10
    } start_state_e;

endpackage : safety_start_pkg

// ### sim/sensor_model.sv
`timescale 1ns/1ps
// Six two-channel sensors; channel two may lag on rising or hold.
module sensor_model #(
    parameter int unsigned TICK_CYCLES = 10
)
(
    input  wire logic        core_clk,
    input  wire logic [5:0]  want,     // Requested level of each pair.
    input  wire logic [5:0]  hold_two, // Channel two keeps its level.
    input  wire logic [31:0] lag_cyc,  // Rising lag of channel two.
    output logic      [5:0]  ch_one,   // First channels.
    output logic      [5:0]  ch_two    // Second channels.
);
    localparam int unsigned REC_CYC = 200 * TICK_CYCLES; // Recovery time.
    int unsigned idle_cyc [6]; // Time since channel one fell.
    int unsigned lag_cnt  [6]; // Time since channel one rose.
    // Starts with all pairs inactive and recovered.
    initial begin
        {ch_one, ch_two} = '0;
        foreach (idle_cyc[i]) idle_cyc[i] = REC_CYC;
    end
    // Moves each pair toward its requested level.
    always @(posedge core_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (ch_one[i]) idle_cyc[i] <= 0;
            else if (idle_cyc[i] < REC_CYC) idle_cyc[i] <= idle_cyc[i] + 1;
            ch_one[i] <= want[i] && (ch_one[i] || idle_cyc[i] >= REC_CYC);
            lag_cnt[i] <= ch_one[i] ? lag_cnt[i] + 1 : 0;
            if (!hold_two[i])
                ch_two[i] <= want[i] && ch_one[i] && (ch_two[i] || lag_cnt[i] >= lag_cyc);
        end
    end
endmodule : sensor_model

// ### sim/start_ctrl_props.sv
`timescale 1ns/1ps
// Port checks of output timing, start type and APB.
module start_ctrl_props
    import safety_start_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = MS_CYCLES
)
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        input_a_channel_one,
    input wire logic        input_a_channel_two,
    input wire logic        input_b_channel_one,
    input wire logic        input_b_channel_two,
    input wire logic        input_c_channel_one,
    input wire logic        input_c_channel_two,
    input wire logic        input_d_channel_one,
    input wire logic        input_d_channel_two,
    input wire logic        input_e_channel_one,
    input wire logic        input_e_channel_two,
    input wire logic        input_f_channel_one,
    input wire logic        input_f_channel_two,
    input wire logic        start_in,
    input wire logic [2:0]  start_selector,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        safety_out_one,
    input wire logic        safety_out_two
);
    localparam int RESP_CYC = (TICK_CYCLES > 50) ? 1000 : 20 * TICK_CYCLES; // Drop limit.
    localparam int WAIT_CYC = POWER_WAIT_MS * TICK_CYCLES; // Power-on wait.
    logic        all_ch; // All twelve channels active.
    int unsigned up_cyc; // Cycles since reset, saturating.
    logic        mon_r;  // Monitored start type seen after reset.
    assign all_ch = &{input_a_channel_one, input_a_channel_two, input_b_channel_one,
                      input_b_channel_two, input_c_channel_one, input_c_channel_two,
                      input_d_channel_one, input_d_channel_two, input_e_channel_one,
                      input_e_channel_two, input_f_channel_one, input_f_channel_two};
    // Time since reset and the start type.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            up_cyc <= 0;
            mon_r  <= 1'b0;
        end else begin
            if (up_cyc < WAIT_CYC) up_cyc <= up_cyc + 1;
            if (up_cyc == 2) mon_r <= start_selector[1];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    outs_equal_a: assert property (safety_out_one == safety_out_two)
        else $error("outputs differ");
    drop_resp_a: assert property (!all_ch |-> ##[0:RESP_CYC] !safety_out_one)
        else $error("output not dropped in time");
    rise_inputs_a: assert property ($rose(safety_out_one) |-> $past(all_ch, 3))
        else $error("output rose without all inputs");
    manual_start_a: assert property ($rose(safety_out_one) && !mon_r |-> $past(start_in, 3))
        else $error("output rose without start");
    mon_edge_a: assert property ($rose(safety_out_one) && mon_r |-> !$past(start_in, 3))
        else $error("monitored rise while start held");
    mon_wait_a: assert property (mon_r && up_cyc < WAIT_CYC |-> !safety_out_one)
        else $error("output on before power-on wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_wait_a: assert property (psel && !penable ##1 psel && penable |=> pready)
        else $error("pready late");
    bad_addr_a: assert property (pready && paddr != CTRL_ADDR && paddr != STATUS_ADDR
        |-> pslverr && prdata == 32'h0) else $error("unmapped address accepted");
    cover property ($rose(safety_out_one));
    cover property ($fell(safety_out_one) && mon_r);
    cover property (pready && pslverr);
endmodule : start_ctrl_props

// ### sim/tb.sv
`timescale 1ns/1ps
// Self-checking bench of the start control block.
module tb;
    import safety_start_pkg::*;
    localparam int MS = 5; // Cycles per millisecond tick.
    localparam int LIMIT = 90000; // Timeout ceiling in cycles.
    logic        core_clk = 0, reset_n = 0, start_in = 0, er;
    logic [2:0]  sel = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, rd, lag = 0, seed = 32;
    logic [5:0]  want = 0, hold_two = 0, ch_one, ch_two;
    logic        pready, pslverr, out_one, out_two;
    logic [31:0] prdata;
    int          err_total = 0, tests_run = 0, cyc = 0, k;
    always #50 core_clk = ~core_clk;
    sensor_model #(.TICK_CYCLES(MS)) sens_u (.core_clk, .want, .hold_two, .lag_cyc(lag),
        .ch_one, .ch_two);
    safety_start_control #(.TICK_CYCLES(MS)) dut_u (.core_clk, .reset_n,
        .input_a_channel_one(ch_one[0]), .input_a_channel_two(ch_two[0]),
        .input_b_channel_one(ch_one[1]), .input_b_channel_two(ch_two[1]),
        .input_c_channel_one(ch_one[2]), .input_c_channel_two(ch_two[2]),
        .input_d_channel_one(ch_one[3]), .input_d_channel_two(ch_two[3]),
        .input_e_channel_one(ch_one[4]), .input_e_channel_two(ch_two[4]),
        .input_f_channel_one(ch_one[5]), .input_f_channel_two(ch_two[5]),
        .start_in, .start_selector(sel), .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .safety_out_one(out_one), .safety_out_two(out_two));
    // Prints the counts and the verdict, then stops.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    // Cuts a hang short.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            print_verdict();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Bench model: held start turns on unless tested or monitored.
    function automatic logic exp_on(int p);
        return (p % 2 == 0) && ((p / 2) % 2 == 0);
    endfunction : exp_on
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_ms(int ms);
        repeat (ms * MS) @(posedge core_clk);
    endtask : wait_ms
    // Waits up to ms for the output level.
    task automatic wait_out(logic e, int ms);
        int n = 0;
        while (out_one !== e && n < ms * MS) begin
            @(posedge core_clk);
            n++;
        end
        chk("safety_out", e, out_one);
    endtask : wait_out
    // Output must hold its level for ms.
    task automatic stay_out(logic e, int ms);
        logic seen = e;
        repeat (ms * MS) begin
            @(posedge core_clk);
            if (out_one !== e) seen = out_one;
        end
        chk("steady_out", e, seen);
    endtask : stay_out
    task automatic do_reset(int p, logic [5:0] w, logic st);
        @(posedge core_clk);
        reset_n <= 1'b0;
        sel <= p[2:0];
        want <= w;
        start_in <= st;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask : do_reset
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        do_reset(0, 6'h00, 1'b0);
        chk("out_reset", 1'b0, out_one);
        apb(1'b0, CTRL_ADDR, 0);
        chk("ctrl_reset", 32'h1, rd);
        apb(1'b0, 8'h08, 0);
        chk("unmapped_err", 1'b1, er);
        $display("test reset done");
        // each of the eight selector settings with six pairs active
        for (int p = 0; p < 8; p++) begin
            do_reset(p, 6'h3f, 1'b1);
            if (exp_on(p)) wait_out(1'b1, 100);
            else stay_out(1'b0, 100);
            sel <= ~p[2:0];
            apb(1'b1, STATUS_ADDR, xs());
            apb(1'b0, STATUS_ADDR, 0);
            chk("sel_field", p[2:0], rd[15:13]);
        end
        $display("test selector done");
        do_reset(0, 6'h3f, 1'b1);
        for (int i = 0; i < 6; i++) begin
            want[i] <= 1'b0;
            wait_out(1'b0, 20);
            want[i] <= 1'b1;
            wait_out(1'b1, 300);
        end
        k = xs() % 6;
        hold_two[k] <= 1'b1;
        want[k] <= 1'b0;
        wait_out(1'b0, 20);
        want[k] <= 1'b1;
        stay_out(1'b0, 300);
        hold_two[k] <= 1'b0;
        want[k] <= 1'b0;
        wait_ms(10);
        want[k] <= 1'b1;
        wait_out(1'b1, 300);
        $display("test drop and interlock done");
        k = xs() % 6;
        want[k] <= 1'b0;
        lag <= 600 * MS;
        wait_out(1'b0, 20);
        want[k] <= 1'b1;
        stay_out(1'b0, 900);
        want[k] <= 1'b0;
        lag <= xs() % (400 * MS);
        wait_ms(10);
        want[k] <= 1'b1;
        wait_out(1'b1, 700);
        lag <= 0;
        $display("test skew done");
        do_reset(4, 6'h3f, 1'b0);
        stay_out(1'b0, 150);
        start_in <= 1'b1;
        wait_out(1'b1, 100);
        apb(1'b1, CTRL_ADDR, 32'h0);
        wait_out(1'b0, 20);
        apb(1'b1, CTRL_ADDR, 32'h1);
        wait_out(1'b1, 100);
        $display("test manual done");
        do_reset(1, 6'h00, 1'b1);
        wait_ms(10);
        want <= 6'h3f;
        wait_out(1'b1, 300);
        $display("test startup done");
        do_reset(2, 6'h00, 1'b0);
        start_in <= 1'b1;
        want <= 6'h3f;
        wait_ms(300);
        start_in <= 1'b0;
        stay_out(1'b0, 200);
        want <= 6'h00;
        wait_ms(2600);
        start_in <= 1'b1;
        want <= 6'h3f;
        stay_out(1'b0, 100);
        start_in <= 1'b0;
        wait_out(1'b1, 100);
        want <= 6'h00;
        wait_out(1'b0, 20);
        wait_ms(200);
        want <= 6'h3f;
        wait_ms(10);
        start_in <= 1'b1;
        wait_ms(40);
        start_in <= 1'b0;
        stay_out(1'b0, 150);
        $display("test monitored done");
        print_verdict();
    end
endmodule : tb
bind safety_start_control start_ctrl_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
    .core_clk, .reset_n, .input_a_channel_one, .input_a_channel_two, .input_b_channel_one,
    .input_b_channel_two, .input_c_channel_one, .input_c_channel_two, .input_d_channel_one,
    .input_d_channel_two, .input_e_channel_one, .input_e_channel_two, .input_f_channel_one,
    .input_f_channel_two, .start_in, .start_selector, .psel, .penable, .paddr, .pready,
    .prdata, .pslverr, .safety_out_one, .safety_out_two);
